//--- src/du_pkg.sv
// Constants shared by the dual asynchronous receiver/transmitter core.
// Assumes one 200 MHz clock; every pin arrives asynchronously to it.
// Summary of operation
// - Data bus is driven only while chip select is low, else released.
// - Data bus bit zero is the least significant bit.
// - Write loads addressed register; it takes effect at write strobe rising edge.
// - Read drives addressed register contents; cycle starts at read strobe falling edge.
// - Four address bits pick the register or port accessed.
// - Reset clears status, mask, output registers, stops timer, idles channels at mark.
// - Interrupt output goes low while any enabled interrupting condition is true.
// - Receivers take least significant bit first; high is mark, low is space.
// - Transmitters send LSB first and hold mark when disabled, idle or looped back.
// - Outputs zero and one are general outputs or request-to-send with auto release.
// - Output two is general, channel A transmit 16x/1x clock or receive 1x clock.
// - Output three is general, timer output, channel B transmit or receive 1x clock.
// - Outputs four and five may show receiver ready or full, active low.
// - Outputs six and seven may show transmitter ready, active low.
// - Inputs zero and one are readable and serve as clear-to-send, active low.
// - Input two is readable and may clock the counter/timer.
// - Input three may clock channel A transmitter; bits shift on its falling edge.
// - A receiver external clock samples data on its rising edge.
// - A general purpose output pin is the complement of its register bit.
// - Only conditions enabled in the interrupt mask assert the interrupt.
package du_pkg;
    localparam logic [3:0] REG_MODE_A = 4'h0;
    localparam logic [3:0] REG_STAT_A = 4'h1;
    localparam logic [3:0] REG_DATA_A = 4'h3;
    localparam logic [3:0] CH_STRIDE = 4'h8;
    localparam logic [3:0] REG_AUX = 4'h4;
    localparam logic [3:0] REG_IMASK = 4'h5;
    localparam logic [3:0] REG_OUTPUT_FUNCTION_CONFIG = 4'hD;
    localparam logic [3:0] REG_OPR_SET = 4'hE;
    localparam logic [3:0] REG_OPR_CLR = 4'hF;
    localparam int MD_TXEN = 0;
    localparam int MD_RXEN = 1;
    localparam int MD_LOOP = 2;
    localparam int MD_TXEXT = 3;
    localparam int MD_RXEXT = 4;
    localparam int MD_RTS_TX = 5;
    localparam int MD_RTS_RX = 6;
    localparam int MD_CTS = 7;
    localparam int AX_RUN = 0;
    localparam int AX_EXT = 1;
    localparam int OC_OP2 = 0;
    localparam int OC_OP3 = 2;
    localparam int OC_OP4 = 4;
    localparam logic [1:0] SEL_GP = 2'h0;
    localparam logic [1:0] SEL_ALT1 = 2'h1;
    localparam logic [1:0] SEL_ALT2 = 2'h2;
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [3:0] FRAME_BITS = 4'hA;
    localparam logic [3:0] LAST_DATA = 4'h8;
    localparam logic [3:0] MID_SAMPLE = 4'h7;
    localparam int CLK_HZ = 200000000;
    localparam int BAUD = 115200;
    localparam int HALF16_DIV = CLK_HZ / (BAUD * 32);
    localparam logic [15:0] CT_DIV_DEF = 16'h0010;
endpackage : du_pkg

//--- src/du_top.sv
// Dual-channel asynchronous receiver/transmitter with host strobe port and pin mux.
// Assumes an asynchronous host bus and pins; all are synchronised to clk here.
module du_top #(
    parameter int HALF16_DIV = du_pkg::HALF16_DIV,
    parameter logic [15:0] CT_DIV = du_pkg::CT_DIV_DEF
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic [3:0] register_address,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe,
    output logic irq_out_n,
    input wire logic serial_in_chan_a,
    input wire logic serial_in_chan_b,
    output logic serial_out_chan_a,
    output logic serial_out_chan_b,
    input wire logic [6:0] multipurpose_inputs,
    output logic [7:0] multipurpose_outputs
);
    // Pin sampling: two flops, then a third stage used only for edge detection.
    logic [23:0] s1, s2, p3;
    wire [23:0] pins = {chip_select_n, write_strobe_n, read_strobe_n, register_address,
                        host_data_in, serial_in_chan_b, serial_in_chan_a,
                        multipurpose_inputs};
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1 <= 24'hFFFFFF;
            s2 <= 24'hFFFFFF;
            p3 <= 24'hFFFFFF;
        end else begin
            s1 <= pins;
            s2 <= s1;
            p3 <= s2;
        end
    end
    wire cs_n = s2[23];
    wire wr_n = s2[22];
    wire rd_n = s2[21];
    wire [3:0] addr = s2[20:17];
    wire [7:0] din = s2[16:9];
    wire [1:0] rx_pin = s2[8:7];
    wire [6:0] ip = s2[6:0];
    wire [6:0] ip_rise = ip & ~p3[6:0];
    wire [6:0] ip_fall = ~ip & p3[6:0];
    wire wr_rise = wr_n && !p3[22];
    wire rd_fall = !rd_n && p3[21] && !cs_n;

    // Write address and data are captured while the strobe is low, since the host
    // only guarantees them up to the rising edge.
    logic [3:0] w_addr;
    logic [7:0] w_data;
    logic w_valid;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            w_addr <= 4'h0;
            w_data <= 8'h00;
            w_valid <= 1'b0;
        end else if (!wr_n && !cs_n) begin
            w_addr <= addr;
            w_data <= din;
            w_valid <= 1'b1;
        end else if (wr_rise) begin
            w_valid <= 1'b0;
        end
    end
    wire wr_ev = wr_rise && w_valid;

    // Baud tick: half period toggles a phase flop, giving a 16x clock and tick.
    logic [15:0] bdiv;
    logic ph16;
    wire half_tick = (bdiv == 16'(HALF16_DIV - 1));
    wire tick16 = half_tick && ph16;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bdiv <= 16'h0000;
            ph16 <= 1'b0;
        end else begin
            bdiv <= half_tick ? 16'h0000 : bdiv + 16'h0001;
            ph16 <= ph16 ^ half_tick;
        end
    end

    // Per-channel state, indexed by channel: 0 is A, 1 is B.
    logic [7:0] mode [2];
    logic [7:0] rx_data [2];
    logic [3:0] tx_sub [2];
    logic [3:0] rx_sub [2];
    logic [1:0] rx_rdy, tx_rdy, tx_emp, ovr, tx_done, tx_line;
    wire [1:0] tx_ext_fall = {ip_fall[5], ip_fall[3]};
    wire [1:0] rx_ext_rise = {ip_rise[6], ip_rise[4]};
    wire [1:0] cts_ok = ~ip[1:0];

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_ch
            localparam logic [3:0] BASE = (i == 0) ? 4'h0 : du_pkg::CH_STRIDE;
            wire sel_mode = wr_ev && w_addr == (BASE | du_pkg::REG_MODE_A);
            wire sel_stat = wr_ev && w_addr == (BASE | du_pkg::REG_STAT_A);
            wire sel_data = wr_ev && w_addr == (BASE | du_pkg::REG_DATA_A);
            wire rd_data = rd_fall && addr == (BASE | du_pkg::REG_DATA_A);
            logic [7:0] hold;
            logic [9:0] shf;
            logic [3:0] tcnt, rcnt;
            logic [7:0] rshf;
            logic full, tbusy, rbusy;
            wire txen = mode[i][du_pkg::MD_TXEN];
            wire step = mode[i][du_pkg::MD_TXEXT] ? tx_ext_fall[i]
                                                  : (tick16 && tx_sub[i] == 4'hF);
            wire start = !tbusy && full && txen && (!mode[i][du_pkg::MD_CTS] || cts_ok[i]);
            assign tx_line[i] = tbusy ? shf[0] : 1'b1;
            assign tx_rdy[i] = txen && !full;
            assign tx_emp[i] = txen && !full && !tbusy;
            assign tx_done[i] = tbusy && step && tcnt == 4'h1 && !full;

            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    mode[i] <= du_pkg::RST_REG;
                end else if (sel_mode) begin
                    mode[i] <= w_data;
                end
            end

            // Transmitter: start bit, eight data bits from bit zero up, stop bit.
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    hold <= 8'h00;
                    full <= 1'b0;
                    shf <= 10'h3FF;
                    tcnt <= 4'h0;
                    tbusy <= 1'b0;
                    tx_sub[i] <= 4'h0;
                end else begin
                    if (tick16) begin
                        tx_sub[i] <= tx_sub[i] + 4'h1;
                    end
                    if (start) begin
                        shf <= {1'b1, hold, 1'b0};
                        tcnt <= du_pkg::FRAME_BITS;
                        tbusy <= 1'b1;
                        tx_sub[i] <= 4'h0;
                    end else if (tbusy && step) begin
                        shf <= {1'b1, shf[9:1]};
                        tcnt <= tcnt - 4'h1;
                        tbusy <= (tcnt != 4'h1);
                    end
                    if (sel_data) begin
                        hold <= w_data;
                        full <= 1'b1;
                    end else if (start) begin
                        full <= 1'b0;
                    end
                end
            end

            // Receiver; local loopback feeds it from the transmitter's own line.
            wire line = mode[i][du_pkg::MD_LOOP] ? tx_line[i] : rx_pin[i];
            wire ext = mode[i][du_pkg::MD_RXEXT];
            wire samp = ext ? rx_ext_rise[i] : (tick16 && rx_sub[i] == du_pkg::MID_SAMPLE);
            wire deliver = rbusy && samp && rcnt == 4'h9;
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    rbusy <= 1'b0;
                    rcnt <= 4'h0;
                    rshf <= 8'h00;
                    rx_sub[i] <= 4'h0;
                    rx_data[i] <= 8'h00;
                    rx_rdy[i] <= 1'b0;
                    ovr[i] <= 1'b0;
                end else begin
                    if (tick16) begin
                        rx_sub[i] <= rx_sub[i] + 4'h1;
                    end
                    if (!rbusy) begin
                        if (mode[i][du_pkg::MD_RXEN] && !line && (!ext || samp)) begin
                            rbusy <= 1'b1;
                            rcnt <= ext ? 4'h1 : 4'h0;
                            rx_sub[i] <= 4'h0;
                        end
                    end else if (samp) begin
                        if (rcnt == 4'h0) begin
                            rbusy <= !line;
                            rcnt <= 4'h1;
                        end else if (rcnt <= du_pkg::LAST_DATA) begin
                            rshf <= {line, rshf[7:1]};
                            rcnt <= rcnt + 4'h1;
                        end else begin
                            rbusy <= 1'b0;
                            rx_data[i] <= rshf;
                        end
                    end
                    // A character landing in the same cycle as the read keeps ready set.
                    if (deliver) begin
                        rx_rdy[i] <= 1'b1;
                    end else if (rd_data) begin
                        rx_rdy[i] <= 1'b0;
                    end
                    if (deliver && rx_rdy[i] && !rd_data) begin
                        ovr[i] <= 1'b1;
                    end else if (sel_stat) begin
                        ovr[i] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Host registers.
    logic [7:0] imask, output_levels_register, output_function_config, aux;
    logic [3:0] ip_chg;
    wire sel_aux = wr_ev && w_addr == du_pkg::REG_AUX;
    wire sel_imask = wr_ev && w_addr == du_pkg::REG_IMASK;
    wire sel_output_function_config = wr_ev && w_addr == du_pkg::REG_OUTPUT_FUNCTION_CONFIG;
    wire sel_set = wr_ev && w_addr == du_pkg::REG_OPR_SET;
    wire sel_clr = wr_ev && w_addr == du_pkg::REG_OPR_CLR;
    wire rd_chg = rd_fall && addr == du_pkg::REG_AUX;
    wire [1:0] rts_drop;
    assign rts_drop[0] = (mode[0][du_pkg::MD_RTS_TX] && tx_done[0])
                      || (mode[0][du_pkg::MD_RTS_RX] && rx_rdy[0]);
    assign rts_drop[1] = (mode[1][du_pkg::MD_RTS_TX] && tx_done[1])
                      || (mode[1][du_pkg::MD_RTS_RX] && rx_rdy[1]);
    wire [7:0] opr_set = sel_set ? w_data : 8'h00;
    wire [7:0] opr_clr = (sel_clr ? w_data : 8'h00) | {6'h00, rts_drop};
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            imask <= du_pkg::RST_REG;
            output_levels_register <= du_pkg::RST_REG;
            output_function_config <= du_pkg::RST_REG;
            aux <= du_pkg::RST_REG;
            ip_chg <= 4'h0;
        end else begin
            imask <= sel_imask ? w_data : imask;
            output_function_config <= sel_output_function_config ? w_data : output_function_config;
            aux <= sel_aux ? w_data : aux;
            output_levels_register <= (output_levels_register | opr_set) & ~opr_clr;
            ip_chg <= (ip_rise[3:0] | ip_fall[3:0]) | (rd_chg ? 4'h0 : ip_chg);
        end
    end

    // Counter/timer: square wave from the clock or input two, halted unless run is set.
    logic [15:0] ct_cnt;
    logic ct_out;
    wire ct_src = aux[du_pkg::AX_EXT] ? ip_rise[2] : 1'b1;
    wire ct_wrap = ct_src && ct_cnt == CT_DIV - 16'h0001;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ct_cnt <= 16'h0000;
            ct_out <= 1'b1;
        end else if (!aux[du_pkg::AX_RUN]) begin
            ct_cnt <= 16'h0000;
            ct_out <= 1'b1;
        end else if (ct_src) begin
            ct_cnt <= ct_wrap ? 16'h0000 : ct_cnt + 16'h0001;
            ct_out <= ct_out ^ ct_wrap;
        end
    end

    wire [7:0] interrupt_status = {ovr[0] | ovr[1], tx_emp[1], rx_rdy[1], tx_rdy[1],
                      |ip_chg, tx_emp[0], rx_rdy[0], tx_rdy[0]};
    wire [7:0] stat_a = {3'h0, ovr[0], tx_emp[0], tx_rdy[0], rx_rdy[0], rx_rdy[0]};
    wire [7:0] stat_b = {3'h0, ovr[1], tx_emp[1], tx_rdy[1], rx_rdy[1], rx_rdy[1]};

    // Read multiplexer; the status and data views of channel B sit one stride up.
    logic [7:0] rd_mux;
    always_comb begin
        case (addr)
            du_pkg::REG_MODE_A: rd_mux = mode[0];
            du_pkg::REG_STAT_A: rd_mux = stat_a;
            du_pkg::REG_DATA_A: rd_mux = rx_data[0];
            du_pkg::REG_AUX: rd_mux = {4'h0, ip_chg};
            du_pkg::REG_IMASK: rd_mux = interrupt_status;
            du_pkg::CH_STRIDE | du_pkg::REG_MODE_A: rd_mux = mode[1];
            du_pkg::CH_STRIDE | du_pkg::REG_STAT_A: rd_mux = stat_b;
            du_pkg::CH_STRIDE | du_pkg::REG_DATA_A: rd_mux = rx_data[1];
            du_pkg::REG_OUTPUT_FUNCTION_CONFIG: rd_mux = {1'b1, ip};
            default: rd_mux = 8'h00;
        endcase
    end

    // Output pin functions.
    wire [1:0] op2_sel = output_function_config[du_pkg::OC_OP2 +: 2];
    wire [1:0] op3_sel = output_function_config[du_pkg::OC_OP3 +: 2];
    wire op2 = (op2_sel == du_pkg::SEL_GP) ? ~output_levels_register[2]
             : (op2_sel == du_pkg::SEL_ALT1) ? ph16
             : (op2_sel == du_pkg::SEL_ALT2) ? tx_sub[0][3] : rx_sub[0][3];
    wire op3 = (op3_sel == du_pkg::SEL_GP) ? ~output_levels_register[3]
             : (op3_sel == du_pkg::SEL_ALT1) ? ct_out
             : (op3_sel == du_pkg::SEL_ALT2) ? tx_sub[1][3] : rx_sub[1][3];
    wire [3:0] hi_alt = {~tx_rdy[1], ~tx_rdy[0], ~rx_rdy[1], ~rx_rdy[0]};
    wire [3:0] hi_sel = output_function_config[7:du_pkg::OC_OP4];
    wire [3:0] hi_out = (hi_sel & hi_alt) | (~hi_sel & ~output_levels_register[7:4]);
    wire [7:0] next_op = {hi_out, op3, op2, ~output_levels_register[1:0]};
    wire next_irq_n = ~|(interrupt_status & imask);
    wire next_txa = !mode[0][du_pkg::MD_TXEN] || mode[0][du_pkg::MD_LOOP] || tx_line[0];
    wire next_txb = !mode[1][du_pkg::MD_TXEN] || mode[1][du_pkg::MD_LOOP] || tx_line[1];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            host_data_out <= 8'h00;
            host_data_oe <= 1'b0;
            irq_out_n <= 1'b1;
            serial_out_chan_a <= 1'b1;
            serial_out_chan_b <= 1'b1;
            multipurpose_outputs <= 8'hFF;
        end else begin
            host_data_out <= rd_mux;
            host_data_oe <= !cs_n && !rd_n;
            irq_out_n <= next_irq_n;
            serial_out_chan_a <= next_txa;
            serial_out_chan_b <= next_txb;
            multipurpose_outputs <= next_op;
        end
    end
endmodule : du_top

//--- tb/du_monitor.sv
// Port-level checker for the dual receiver/transmitter top module.
// Assumes one clock and an asynchronous active-high reset; attached by bind.
module du_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic [3:0] register_address,
    input wire logic [7:0] host_data_in,
    input wire logic [7:0] host_data_out,
    input wire logic host_data_oe,
    input wire logic irq_out_n,
    input wire logic serial_in_chan_a,
    input wire logic serial_in_chan_b,
    input wire logic serial_out_chan_a,
    input wire logic serial_out_chan_b,
    input wire logic [6:0] multipurpose_inputs,
    input wire logic [7:0] multipurpose_outputs
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Six cycles cover the worst synchroniser latency of three.
    sequence s_read(logic [3:0] a);
        (!chip_select_n && !read_strobe_n && register_address == a
            && $stable(multipurpose_inputs))[*6];
    endsequence
    sequence s_release;
        $fell(rst);
    endsequence
    chk_cs_releases_bus: assert property (chip_select_n[*6] |-> !host_data_oe)
        else $error("data bus driven without chip select");
    chk_read_drives: assert property ((!chip_select_n && !read_strobe_n)[*6] |-> host_data_oe)
        else $error("read cycle does not drive the data bus");
    chk_no_read_idle: assert property (read_strobe_n[*6] |-> !host_data_oe)
        else $error("data bus driven without a read strobe");
    chk_reset_levels: assert property (s_release |-> multipurpose_outputs == 8'hFF
        && serial_out_chan_a && serial_out_chan_b && irq_out_n && !host_data_oe)
        else $error("outputs not at reset levels");
    chk_input_read: assert property (s_read(4'hD) |-> host_data_out == {1'b1, multipurpose_inputs})
        else $error("input port read mismatch");
    chk_unmapped_zero: assert property (s_read(4'h2) |-> host_data_out == 8'h00)
        else $error("unmapped read not zero");
    chk_irq_masked: assert property (s_release |-> irq_out_n[*8])
        else $error("interrupt asserted with all conditions masked");
    chk_tx_mark: assert property (s_release |-> (serial_out_chan_a && serial_out_chan_b)[*8])
        else $error("idle transmitter not at mark");
endmodule : du_monitor

bind du_top du_monitor mon (.clk, .rst, .chip_select_n, .write_strobe_n, .read_strobe_n,
    .register_address, .host_data_in, .host_data_out, .host_data_oe, .irq_out_n,
    .serial_in_chan_a, .serial_in_chan_b, .serial_out_chan_a, .serial_out_chan_b,
    .multipurpose_inputs, .multipurpose_outputs);

//--- tb/du_term.sv
// Remote serial terminal: sends and receives 8N1 frames at a fixed bit length.
// Assumes the bench calls its tasks hierarchically; the line idles at mark.
module du_term #(
    parameter int BIT_CLKS = 64
) (
    input wire logic clk,
    input wire logic line_in,
    output logic line_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial line_out = 1'b1;
    task automatic send(input logic [7:0] b);
        @(posedge clk);
        line_out <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge clk);
            line_out <= b[i];
        end
        repeat (BIT_CLKS) @(posedge clk);
        line_out <= 1'b1;
        repeat (BIT_CLKS) @(posedge clk);
    endtask : send
    // Samples mid-bit so that a skew of up to half a bit is tolerated.
    task automatic recv(output logic [7:0] b, output logic ok);
        int n = 0;
        ok = 1'b0;
        b = 8'h00;
        while (line_in !== 1'b0 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        if (n < 4000) begin
            repeat (BIT_CLKS / 2) @(posedge clk);
            ok = (line_in === 1'b0);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CLKS) @(posedge clk);
                b[i] = line_in;
            end
            repeat (BIT_CLKS) @(posedge clk);
            ok = ok && (line_in === 1'b1);
        end
    endtask : recv
endmodule : du_term

//--- tb/dual_uart_host_and_pin_interface_bench.sv
// Self-checking bench for the dual receiver/transmitter top module.
// Assumes du_monitor is bound and two du_term models sit on the serial lines.
module dual_uart_host_and_pin_interface_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 2;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic chip_select_n = 1'b1;
    logic write_strobe_n = 1'b1;
    logic read_strobe_n = 1'b1;
    logic [3:0] register_address = 4'h0;
    logic [7:0] host_data_in = 8'h00;
    logic [6:0] multipurpose_inputs = 7'h7F;
    logic [7:0] host_data_out, multipurpose_outputs;
    logic host_data_oe, irq_out_n, serial_in_chan_a, serial_in_chan_b;
    logic serial_out_chan_a, serial_out_chan_b;
    int errors = 0;
    int checks = 0;
    int cycles = 0;
    always #2.5 clk = ~clk;
    du_top #(.HALF16_DIV(HALF), .CT_DIV(16'h0002)) dut (.clk(clk), .rst(rst),
        .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
        .read_strobe_n(read_strobe_n), .register_address(register_address),
        .host_data_in(host_data_in), .host_data_out(host_data_out),
        .host_data_oe(host_data_oe), .irq_out_n(irq_out_n),
        .serial_in_chan_a(serial_in_chan_a), .serial_in_chan_b(serial_in_chan_b),
        .serial_out_chan_a(serial_out_chan_a), .serial_out_chan_b(serial_out_chan_b),
        .multipurpose_inputs(multipurpose_inputs), .multipurpose_outputs(multipurpose_outputs));
    du_term #(.BIT_CLKS(32 * HALF)) term_a (.clk(clk), .line_in(serial_out_chan_a),
        .line_out(serial_in_chan_a));
    du_term #(.BIT_CLKS(32 * HALF)) term_b (.clk(clk), .line_in(serial_out_chan_b),
        .line_out(serial_in_chan_b));
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check8
    // Strobes are held well beyond the three-cycle minimum of the synchroniser.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        register_address <= a;
        host_data_in <= d;
        chip_select_n <= 1'b0;
        write_strobe_n <= 1'b0;
        repeat (5) @(posedge clk);
        write_strobe_n <= 1'b1;
        repeat (4) @(posedge clk);
        chip_select_n <= 1'b1;
        repeat (5) @(posedge clk);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic cs_n, output logic [7:0] d);
        @(posedge clk);
        register_address <= a;
        chip_select_n <= cs_n;
        read_strobe_n <= 1'b0;
        repeat (7) @(posedge clk);
        d = host_data_out;
        check8({7'h00, host_data_oe}, {7'h00, ~cs_n});
        read_strobe_n <= 1'b1;
        chip_select_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask : rd
    task automatic t_reset();
        logic [7:0] d;
        check8(multipurpose_outputs, 8'hFF);
        check8({6'h00, serial_out_chan_a, serial_out_chan_b}, 8'h03);
        check8({7'h00, irq_out_n}, 8'h01);
        rd(4'h1, 1'b0, d);
        check8(d, 8'h00);
        rd(4'h5, 1'b0, d);
        check8(d, 8'h00);
    endtask : t_reset
    task automatic t_outputs();
        wr(4'hE, 8'hA5);
        check8(multipurpose_outputs, 8'h5A);
        wr(4'hF, 8'h05);
        check8(multipurpose_outputs, 8'h5F);
        wr(4'hF, 8'hFF);
        check8(multipurpose_outputs, 8'hFF);
    endtask : t_outputs
    task automatic t_inputs();
        logic [7:0] d;
        multipurpose_inputs <= 7'h2A;
        rd(4'hD, 1'b0, d);
        check8(d, 8'hAA);
        multipurpose_inputs <= 7'h4D;
        rd(4'hD, 1'b0, d);
        check8(d, 8'hCD);
        wr(4'h2, 8'h3C);
        rd(4'h2, 1'b0, d);
        check8(d, 8'h00);
        rd(4'hD, 1'b1, d);
    endtask : t_inputs
    task automatic t_tx_irq();
        logic [7:0] b;
        logic ok;
        wr(4'h0, 8'h01);
        check8({7'h00, irq_out_n}, 8'h01);
        fork
            term_a.recv(b, ok);
            wr(4'h3, 8'hC3);
        join
        check8({7'h00, ok}, 8'h01);
        check8(b, 8'hC3);
        wr(4'h5, 8'h01);
        check8({7'h00, irq_out_n}, 8'h00);
        wr(4'h5, 8'h00);
        check8({7'h00, irq_out_n}, 8'h01);
    endtask : t_tx_irq
    task automatic t_rx_b();
        logic [7:0] d;
        wr(4'h8, 8'h02);
        wr(4'hD, 8'h20);
        check8({7'h00, multipurpose_outputs[5]}, 8'h01);
        term_b.send(8'h96);
        rd(4'h9, 1'b0, d);
        check8(d & 8'h01, 8'h01);
        check8({7'h00, multipurpose_outputs[5]}, 8'h00);
        rd(4'hB, 1'b0, d);
        check8(d, 8'h96);
        check8({7'h00, multipurpose_outputs[5]}, 8'h01);
    endtask : t_rx_b
    task automatic t_pins();
        logic [7:0] d;
        wr(4'h8, 8'h42);
        wr(4'hE, 8'h02);
        check8(multipurpose_outputs & 8'h02, 8'h00);
        term_b.send(8'h5A);
        check8(multipurpose_outputs & 8'h02, 8'h02);
        rd(4'hB, 1'b0, d);
        check8(d, 8'h5A);
        wr(4'hD, 8'hC5);
        check8(multipurpose_outputs & 8'hC0, 8'h80);
        d[0] = multipurpose_outputs[2];
        repeat (2) @(posedge clk);
        check8({7'h00, multipurpose_outputs[2]}, {7'h00, ~d[0]});
        wr(4'h4, 8'h03);
        check8(multipurpose_outputs & 8'h08, 8'h08);
        repeat (2) begin
            multipurpose_inputs[2] <= 1'b0;
            repeat (4) @(posedge clk);
            multipurpose_inputs[2] <= 1'b1;
            repeat (6) @(posedge clk);
        end
        check8(multipurpose_outputs & 8'h08, 8'h00);
        wr(4'h4, 8'h00);
        check8(multipurpose_outputs & 8'h08, 8'h08);
    endtask : t_pins
    // External clocks run at the terminal's bit rate, each rising edge about half a bit into a bit.
    task automatic t_ext();
        logic [7:0] b;
        logic ok;
        wr(4'h0, 8'h09);
        fork
            term_a.recv(b, ok);
            begin
                wr(4'h3, 8'h3A);
                repeat (10) begin
                    repeat (32) @(posedge clk);
                    multipurpose_inputs[3] <= 1'b0;
                    repeat (32) @(posedge clk);
                    multipurpose_inputs[3] <= 1'b1;
                end
            end
        join
        check8({7'h00, ok}, 8'h01);
        check8(b, 8'h3A);
        wr(4'h0, 8'h12);
        fork
            term_a.send(8'hA7);
            repeat (10) begin
                repeat (32) @(posedge clk);
                multipurpose_inputs[4] <= 1'b1;
                repeat (32) @(posedge clk);
                multipurpose_inputs[4] <= 1'b0;
            end
        join
        rd(4'h3, 1'b0, b);
        check8(b, 8'hA7);
    endtask : t_ext
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish
    // The run needs about 3600 cycles; the ceiling leaves wide margin.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            $display("unexpected at %0t: timeout", $time);
            tally_and_finish();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_reset();
        t_outputs();
        t_inputs();
        t_tx_irq();
        t_rx_b();
        t_pins();
        t_ext();
        tally_and_finish();
    end
endmodule : dual_uart_host_and_pin_interface_bench
